// ---- core/mss_pkg.sv ----
`default_nettype none
package mss_pkg;
   localparam int CUR_W = 16;          // current magnitude, units of 0.1 x In
   localparam int TIM_W = 16;          // stall/start times in ms
   localparam int ACC_W = 48;          // accumulated current-squared-time
   localparam int CLK_HZ = 40_000_000;
   localparam int MS_CYC = CLK_HZ / 1000;  // cycles per millisecond tick
   localparam int RISE_MS = 10;            // start detect rise window, ms
   localparam logic [TIM_W-1:0] RISE_TICKS = 16'h000A;
   localparam logic [15:0] MS_CYC_M1 = 16'(MS_CYC - 1);
   localparam logic [ACC_W-1:0] ACC_RST = 48'h0000_0000_0000;
   localparam logic [TIM_W-1:0] TIM_RST = 16'h0000;

   typedef enum logic [2:0] {
      FRC_NORMAL,
      FRC_START,
      FRC_TIME_TRIP,
      FRC_CAP_TRIP,
      FRC_BLOCKED
   } mss_force_t;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_START,
      ST_RUN,
      ST_STALL
   } mss_state_t;
endpackage : mss_pkg
`default_nettype wire

// ---- core/mss_monitor.sv ----
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - definite time or current-squared-time supervision
// - lower current gives longer permitted time
// - limit from manual or hot/cold stall
// - no trip while accumulation below limit
// - overlong start without rotation trips
// - speed switch rotation extends start time
// - trip beyond safe stall time while the speed switch shows rotation
// - stall after start uses start settings
// - start only on rise within 10 ms
// - forcing holds one of four states
module mss_monitor (
   input  wire logic                       clk_sys_in,
   input  wire logic                       nrst_in,
   input  wire logic                       ce_in,
   input  wire logic [mss_pkg::CUR_W-1:0]  cur_l1_in,
   input  wire logic [mss_pkg::CUR_W-1:0]  cur_l2_in,
   input  wire logic [mss_pkg::CUR_W-1:0]  cur_l3_in,
   input  wire logic [mss_pkg::CUR_W-1:0]  no_load_cur_in,
   input  wire logic [mss_pkg::CUR_W-1:0]  start_det_cur_in,
   input  wire logic [mss_pkg::CUR_W-1:0]  nom_start_cur_in,
   input  wire logic [mss_pkg::CUR_W-1:0]  max_ovl_cur_in,
   input  wire logic                       i2t_mode_in,
   input  wire logic                       auto_stall_in,
   input  wire logic                       thermal_hot_in,
   input  wire logic [mss_pkg::TIM_W-1:0]  manual_time_in,
   input  wire logic [mss_pkg::TIM_W-1:0]  hot_stall_time_in,
   input  wire logic [mss_pkg::TIM_W-1:0]  cold_stall_time_in,
   input  wire logic [mss_pkg::TIM_W-1:0]  safe_stall_time_in,
   input  wire logic                       speed_sw_use_in,
   input  wire logic                       speed_sw_in,
   input  wire logic                       stall_mon_en_in,
   input  wire logic [2:0]                 force_in,
   output logic                            starting_out,
   output logic                            locked_rotor_check_out,
   output logic                            trip_time_out,
   output logic                            trip_cap_out,
   output logic                            trip_out,
   output logic                            blocked_out
);
   ////////////////////////////////////////////////////////////////////////////
   logic rst_s1_reg, rst_n;
   logic sw_s1_reg, sw_reg;
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rst_s1_reg <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_s1_reg <= 1'b1;
         rst_n <= rst_s1_reg;
      end
   end
   // speed switch is a field pin, synchronised before use
   always_ff @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
         sw_s1_reg <= 1'b0;
         sw_reg <= 1'b0;
      end else if (ce_in) begin
         sw_s1_reg <= speed_sw_in;
         sw_reg <= sw_s1_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   logic [mss_pkg::CUR_W-1:0] imax;
   always_comb begin
      imax = cur_l1_in;
      if (cur_l2_in > imax) imax = cur_l2_in;
      if (cur_l3_in > imax) imax = cur_l3_in;
   end
   logic above_nl, above_sd, above_ovl;
   assign above_nl = imax > no_load_cur_in;
   assign above_sd = imax > start_det_cur_in;
   assign above_ovl = imax > max_ovl_cur_in;

   logic [15:0] pre_reg;
   logic        tick;
   assign tick = (pre_reg == mss_pkg::MS_CYC_M1);
   always_ff @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) pre_reg <= 16'h0000;
      else if (ce_in) pre_reg <= tick ? 16'h0000 : pre_reg + 16'h0001;
   end

   ////////////////////////////////////////////////////////////////////////////
   // rise window: opens when no-load is passed, start only if start detect is
   // passed before it runs out; slow rises never reach ST_START
   logic [mss_pkg::TIM_W-1:0] rise_reg;
   logic                      rise_open_reg;
   mss_pkg::mss_state_t       st_reg;
   logic                      start_det;
   assign start_det = rise_open_reg && above_sd && (rise_reg <= mss_pkg::RISE_TICKS);
   always_ff @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
         rise_reg <= mss_pkg::TIM_RST;
         rise_open_reg <= 1'b0;
      end else if (ce_in) begin
         if (!above_nl || st_reg != mss_pkg::ST_IDLE) begin
            rise_reg <= mss_pkg::TIM_RST;
            rise_open_reg <= (st_reg == mss_pkg::ST_IDLE) ? 1'b0 : rise_open_reg;
         end else if (!rise_open_reg) begin
            rise_open_reg <= 1'b1;
         end else if (tick && rise_reg <= mss_pkg::RISE_TICKS) begin
            rise_reg <= rise_reg + 16'h0001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   logic [mss_pkg::TIM_W-1:0] limit, time_reg;
   logic [mss_pkg::ACC_W-1:0] acc_reg, acc_lim;
   logic [31:0]               isq;
   assign limit = auto_stall_in ? (thermal_hot_in ? hot_stall_time_in : cold_stall_time_in)
                                : manual_time_in;
   assign isq = imax * imax;
   // capacity = nominal start current squared times permitted time; a lower
   // current accumulates slower and so is allowed longer
   assign acc_lim = 48'(nom_start_cur_in * nom_start_cur_in) * 48'(limit);

   logic supv, tmo_def, tmo_cap, tmo_safe, timeout;
   assign supv = (st_reg == mss_pkg::ST_START) || (st_reg == mss_pkg::ST_STALL);
   assign tmo_def = time_reg >= limit;
   assign tmo_cap = acc_reg >= acc_lim;
   assign tmo_safe = time_reg >= safe_stall_time_in;
   // rotation extends past the set limit, but never past safe stall
   assign timeout = supv && ((((i2t_mode_in ? tmo_cap : tmo_def))
                    && !(speed_sw_use_in && sw_reg))
                    || (speed_sw_use_in && sw_reg && tmo_safe));

   always_ff @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
         time_reg <= mss_pkg::TIM_RST;
         acc_reg <= mss_pkg::ACC_RST;
      end else if (ce_in) begin
         if (!supv) begin
            time_reg <= mss_pkg::TIM_RST;
            acc_reg <= mss_pkg::ACC_RST;
         end else if (tick) begin
            if (time_reg != 16'hFFFF) time_reg <= time_reg + 16'h0001;
            if (!tmo_cap) acc_reg <= acc_reg + 48'(isq);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   logic trip_reg, cap_reg;
   always_ff @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= mss_pkg::ST_IDLE;
      end else if (ce_in) begin
         unique case (st_reg)
            mss_pkg::ST_IDLE:  if (start_det) st_reg <= mss_pkg::ST_START;
            mss_pkg::ST_START: begin
               if (!above_nl) st_reg <= mss_pkg::ST_IDLE;
               else if (!above_ovl) st_reg <= mss_pkg::ST_RUN;
            end
            mss_pkg::ST_RUN: begin
               if (!above_nl) st_reg <= mss_pkg::ST_IDLE;
               else if (above_ovl && stall_mon_en_in) st_reg <= mss_pkg::ST_STALL;
            end
            mss_pkg::ST_STALL: begin
               if (!above_nl) st_reg <= mss_pkg::ST_IDLE;
               else if (!above_ovl && !trip_reg) st_reg <= mss_pkg::ST_RUN;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
         trip_reg <= 1'b0;
         cap_reg <= 1'b0;
      end else if (ce_in) begin
         if (timeout) begin
            trip_reg <= 1'b1;
            cap_reg <= i2t_mode_in && tmo_cap;
         end else if (!above_nl) begin
            trip_reg <= 1'b0;
            cap_reg <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   mss_pkg::mss_force_t frc;
   assign frc = mss_pkg::mss_force_t'(force_in);
   always_comb begin
      starting_out = (st_reg == mss_pkg::ST_START);
      trip_time_out = trip_reg && !cap_reg;
      trip_cap_out = cap_reg;
      blocked_out = 1'b0;
      unique case (frc)
         mss_pkg::FRC_START: begin
            starting_out = 1'b1;
            trip_time_out = 1'b0;
            trip_cap_out = 1'b0;
         end
         mss_pkg::FRC_TIME_TRIP: begin
            trip_time_out = 1'b1;
            trip_cap_out = 1'b0;
         end
         mss_pkg::FRC_CAP_TRIP: begin
            trip_time_out = 1'b0;
            trip_cap_out = 1'b1;
         end
         mss_pkg::FRC_BLOCKED: begin
            starting_out = 1'b0;
            trip_time_out = 1'b0;
            trip_cap_out = 1'b0;
            blocked_out = 1'b1;
         end
         default: ;
      endcase
      trip_out = trip_time_out || trip_cap_out;
      locked_rotor_check_out = supv && (force_in == 3'h0);
   end

   ////////////////////////////////////////////////////////////////////////////
   a_trip_on_timeout: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
      ce_in && timeout |=> trip_reg) else $error("timeout did not trip");
   a_no_trip_below: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
      ce_in && supv && i2t_mode_in && !tmo_cap && !(speed_sw_use_in && sw_reg)
      && !trip_reg && above_nl |=> !trip_reg) else $error("tripped below limit");
   a_switch_extends: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
      ce_in && supv && speed_sw_use_in && sw_reg && !tmo_safe && !trip_reg |=> !trip_reg)
      else $error("speed switch did not extend");
   a_safe_stall: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
      ce_in && supv && tmo_safe && speed_sw_use_in && sw_reg |=> trip_reg)
      else $error("safe stall exceeded without trip");
   a_trip_holds: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
      trip_reg && above_nl |=> trip_reg) else $error("trip dropped early");
   a_trip_clears: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
      ce_in && trip_reg && !above_nl && !timeout |=> !trip_reg)
      else $error("trip not released");
   a_slow_rise: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
      ce_in && st_reg == mss_pkg::ST_IDLE && rise_reg > mss_pkg::RISE_TICKS
      |=> st_reg != mss_pkg::ST_START) else $error("slow rise taken as start");
   a_force_block: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
      force_in == 3'h4 |-> blocked_out && !trip_out) else $error("block force failed");
   a_limit_sel: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
      ce_in && supv && auto_stall_in && thermal_hot_in && !i2t_mode_in
      && !(speed_sw_use_in && sw_reg) && time_reg >= hot_stall_time_in |=> trip_reg)
      else $error("hot stall time not applied");
   a_def_mode: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
      ce_in && supv && !i2t_mode_in && tmo_def && !speed_sw_use_in |=> trip_reg)
      else $error("definite time not tripped");
   a_stall_entry: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
      ce_in && st_reg == mss_pkg::ST_RUN && above_ovl && above_nl && stall_mon_en_in
      |=> st_reg == mss_pkg::ST_STALL) else $error("stall not supervised");
   c_start: cover property (@(posedge clk_sys_in) disable iff (!rst_n)
      st_reg == mss_pkg::ST_IDLE ##1 st_reg == mss_pkg::ST_START);
   c_trip_start: cover property (@(posedge clk_sys_in) disable iff (!rst_n)
      st_reg == mss_pkg::ST_START && timeout);
   c_extended: cover property (@(posedge clk_sys_in) disable iff (!rst_n)
      supv && tmo_def && speed_sw_use_in && sw_reg && !tmo_safe);
   c_stall_trip: cover property (@(posedge clk_sys_in) disable iff (!rst_n)
      st_reg == mss_pkg::ST_STALL && timeout);
endmodule : mss_monitor
`default_nettype wire

// ---- verif/mss_motor_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module mss_motor_model (
   input  wire logic        clk_sys_in,
   input  wire logic [15:0] amp_in,
   input  wire logic [1:0]  rot_in,
   input  wire logic        spin_in,
   output logic      [15:0] cur_l1_out,
   output logic      [15:0] cur_l2_out,
   output logic      [15:0] cur_l3_out,
   output logic             speed_sw_out
);
   logic [15:0] low_cur;
   // phases stay unequal so only the largest one may decide the state
   assign low_cur = amp_in - (amp_in >> 3);
   ////////////////////////////////////////////////////////////////////////////
   // a step on amp_in lands in one cycle: a fast rise
   always_ff @(posedge clk_sys_in) begin
      cur_l1_out   <= (rot_in == 2'd0) ? amp_in : low_cur;
      cur_l2_out   <= (rot_in == 2'd1) ? amp_in : low_cur;
      cur_l3_out   <= (rot_in >= 2'd2) ? amp_in : low_cur;
      speed_sw_out <= spin_in;
   end
endmodule : mss_motor_model
`default_nettype wire

// ---- verif/testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic        clk_sys_in = 1'b0;
   logic        nrst_in    = 1'b0;
   logic [15:0] amp        = 16'h0000;
   logic [1:0]  rot        = 2'b00;
   logic        spin       = 1'b0;
   logic        auto_sel   = 1'b0;
   logic        hot        = 1'b0;
   logic        sw_use     = 1'b0;
   logic [2:0]  frc        = 3'h0;
   logic [15:0] man_t      = 16'h0002;
   logic [15:0] hot_t      = 16'h0001;
   logic [15:0] cold_t     = 16'hFFFF;
   logic [15:0] safe_t     = 16'hFFFF;
   logic        i2t        = 1'b0;
   logic        stall_en   = 1'b0;
   wire logic [15:0] c1, c2, c3;
   wire logic   sw, st, locked_rotor_check, tt, tc, tr, bl;
   int          miscompares = 0;
   int          n_tests     = 0;
   int          n;
   always #12.5 clk_sys_in = ~clk_sys_in;
   mss_motor_model mss_motor_model_i (.clk_sys_in(clk_sys_in), .amp_in(amp), .rot_in(rot),
      .spin_in(spin), .cur_l1_out(c1), .cur_l2_out(c2), .cur_l3_out(c3), .speed_sw_out(sw));
   mss_monitor mss_monitor_i (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .ce_in(1'b1),
      .cur_l1_in(c1), .cur_l2_in(c2), .cur_l3_in(c3), .no_load_cur_in(16'h000A),
      .start_det_cur_in(16'h000F), .nom_start_cur_in(16'h003C), .max_ovl_cur_in(16'h0030),
      .i2t_mode_in(i2t), .auto_stall_in(auto_sel), .thermal_hot_in(hot),
      .manual_time_in(man_t), .hot_stall_time_in(hot_t), .cold_stall_time_in(cold_t),
      .safe_stall_time_in(safe_t), .speed_sw_use_in(sw_use), .speed_sw_in(sw),
      .stall_mon_en_in(stall_en), .force_in(frc), .starting_out(st),
      .locked_rotor_check_out(locked_rotor_check), .trip_time_out(tt), .trip_cap_out(tc),
      .trip_out(tr), .blocked_out(bl));
   ////////////////////////////////////////////////////////////////////////////
   task automatic print_verdict();
      $display("checks %0d, mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : print_verdict
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic tick(input int cnt);
      repeat (cnt) @(posedge clk_sys_in);
      #1;
   endtask : tick
   // bounded wait: a trip that never comes ends the run
   task automatic wait_trip(input int lim, output int cnt);
      cnt = 0;
      while (tr !== 1'b1) begin
         tick(1);
         cnt++;
         if (cnt >= lim) begin
            miscompares++;
            print_verdict();
         end
      end
   endtask : wait_trip
   function automatic logic [3:0] exp_force(input int k);
      case (k)
         1: return 4'b1000;
         2: return 4'b0100;
         3: return 4'b0010;
         4: return 4'b0001;
         default: return 4'b0000;
      endcase
   endfunction : exp_force
   // random locked-rotor level above the overload limit, random peak phase
   task automatic start_motor(input logic [15:0] lo, input logic [15:0] hi);
      @(posedge clk_sys_in);
      rot <= 2'($urandom_range(2, 0));
      amp <= 16'($urandom_range(hi, lo));
      tick(4);
      chk(st, 1'b1);
      chk(locked_rotor_check, 1'b1);
   endtask : start_motor
   // current to zero: the state machine idles and a latched trip releases
   task automatic stop_motor();
      @(posedge clk_sys_in);
      amp <= 16'h0000;
      tick(5);
   endtask : stop_motor
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(91));
      repeat (4) @(posedge clk_sys_in);
      nrst_in <= 1'b1;
      tick(5);
      chk({st, locked_rotor_check, tt, tc, tr, bl}, 16'h0000);
      for (int k = 0; k < 6; k++) begin
         @(posedge clk_sys_in);
         frc <= 3'(k);
         tick(2);
         chk({st, tt, tc, bl}, exp_force(k));
      end
      // zero limit in definite time: trips as soon as the start is seen
      @(posedge clk_sys_in);
      frc   <= 3'h0;
      man_t <= 16'h0000;
      tick(3);
      start_motor(16'h0040, 16'h007F);
      tick(2);
      chk({tr, tt, tc}, 3'b110);
      tick(100);
      chk(tr, 1'b1);
      stop_motor();
      chk(tr, 1'b0);
      // zero capacity: the current-squared-time path trips at once
      @(posedge clk_sys_in);
      i2t <= 1'b1;
      tick(3);
      start_motor(16'h0040, 16'h007F);
      tick(2);
      chk({tr, tt, tc}, 3'b101);
      stop_motor();
      // expected start time plus margin, rounded up to whole ms
      @(posedge clk_sys_in);
      man_t <= 16'h0001;
      tick(3);
      // just above overload one ms of heating stays below capacity, where
      // definite time with the same limit would already have tripped;
      // 40000 edges hold exactly one ms tick
      start_motor(16'h0031, 16'h003B);
      tick(20);
      chk(tr, 1'b0);
      tick(39980);
      chk({tr, st}, 2'b01);
      stop_motor();
      // rotation holds off a zero start limit until safe stall runs out
      @(posedge clk_sys_in);
      i2t    <= 1'b0;
      man_t  <= 16'h0000;
      sw_use <= 1'b1;
      spin   <= 1'b1;
      tick(3);
      start_motor(16'h0040, 16'h007F);
      tick(20);
      chk({tr, st}, 2'b01);
      @(posedge clk_sys_in);
      safe_t <= 16'h0001;
      wait_trip(40010, n);
      chk({tr, tt}, 2'b11);
      stop_motor();
      // stall after a finished start is supervised with the start settings
      @(posedge clk_sys_in);
      sw_use   <= 1'b0;
      spin     <= 1'b0;
      safe_t   <= 16'hFFFF;
      man_t    <= 16'hFFFF;
      stall_en <= 1'b1;
      tick(3);
      start_motor(16'h0040, 16'h007F);
      @(posedge clk_sys_in);
      amp <= 16'h0020;
      tick(4);
      chk({st, locked_rotor_check, tr}, 3'b000);
      @(posedge clk_sys_in);
      man_t <= 16'h0000;
      amp   <= 16'($urandom_range(16'h007F, 16'h0040));
      tick(4);
      chk({tr, tt, locked_rotor_check, st}, 4'b1110);
      stop_motor();
      // hot stall time must win over the huge cold one
      @(posedge clk_sys_in);
      stall_en <= 1'b0;
      auto_sel <= 1'b1;
      hot      <= 1'b1;
      hot_t    <= 16'h0000;
      tick(3);
      start_motor(16'h0040, 16'h007F);
      wait_trip(8, n);
      chk(tr, 1'b1);
      stop_motor();
      @(posedge clk_sys_in);
      hot <= 1'b0;
      tick(3);
      start_motor(16'h0040, 16'h007F);
      tick(20);
      chk(tr, 1'b0);
      @(posedge clk_sys_in);
      nrst_in <= 1'b0;
      amp     <= 16'h0000;
      tick(2);
      chk({st, locked_rotor_check, tr}, 3'b000);
      @(posedge clk_sys_in);
      nrst_in <= 1'b1;
      tick(5);
      chk({st, tr}, 2'b00);
      print_verdict();
   end
endmodule : testbench
`default_nettype wire
